// [include/data_map_pkg.sv]
package data_map_pkg;

  // Special register space locations held inside this block.
  localparam logic [7:0] STATUS_ADDR  = 8'hD0;
  localparam logic [7:0] STACK_ADDR   = 8'h81;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] STACK_RESET  = 8'h07;
  // Highest address that direct mode sends to RAM.
  localparam logic [7:0] DIRECT_TOP   = 8'h7F;
  localparam logic [7:0] BIT_AREA     = 8'h20;
  localparam logic [7:0] FULL_MASK    = 8'hFF;
  localparam int         RAM_BYTES    = 256;

  // Field positions inside the status byte.
  localparam int CARRY_POS  = 7;
  localparam int HALF_POS   = 6;
  localparam int USER0_POS  = 5;
  localparam int BANK_HI    = 4;
  localparam int BANK_LO    = 3;
  localparam int SIGN_POS   = 2;
  localparam int USER1_POS  = 1;
  localparam int PARITY_POS = 0;

  typedef enum logic [2:0] {
    REQ_DIRECT, REQ_INDIRECT, REQ_REG, REQ_BIT,
    REQ_PUSH, REQ_POP, REQ_CODE, REQ_EXT
  } req_kind_e;

  typedef enum logic [2:0] {
    ALU_ADD, ALU_ADD_WITH_CARRY_OP, ALU_SUBTRACT_BORROW_OP, ALU_MUL, ALU_DIV, ALU_OTHER
  } alu_op_e;

  typedef enum logic [1:0] {SRC_HOLD, SRC_RAM, SRC_SFR} src_e;
  typedef enum logic [1:0] {ST_IDLE, ST_POINTER, ST_FINISH} phase_e;

  typedef struct packed {
    phase_e      phase;
    src_e        src;
    logic [7:0]  status;
    logic [7:0]  stackTop;
    logic        isBit;
    logic        isWrite;
    logic [2:0]  bitPos;
    logic [7:0]  addr;
    logic [7:0]  wrData;
    logic [7:0]  hold;
    logic [7:0]  rdData;
    logic        doneValid;
    logic        sfrRead;
    logic        sfrWrite;
    logic [7:0]  sfrAddr;
    logic [7:0]  sfrWdata;
    logic [7:0]  sfrMask;
    logic        codeRead;
    logic        auxRead;
    logic        auxWrite;
    logic        flashWrite;
    logic [15:0] extAddr;
    logic [7:0]  extWdata;
  } map_state_s;

  localparam map_state_s MAP_RESET = '{
    phase: ST_IDLE, src: SRC_HOLD, status: STATUS_RESET,
    stackTop: STACK_RESET, default: '0};

  typedef struct packed {
    logic [7:0] rdata;
  } ram_state_s;

endpackage

// [include/ram_port_if.sv]
`timescale 1ns/10ps
interface ram_port_if;
  logic       en;
  logic       we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output en, output we, output addr, output wdata,
                input rdata);
  modport mem (input en, input we, input addr, input wdata,
               output rdata);
endinterface

// [logic/internal_data_ram.sv]
`timescale 1ns/10ps
module internal_data_ram #(
  parameter int DEPTH = data_map_pkg::RAM_BYTES
) (
  // Clock and reset
  input logic clk_sys,
  input logic rst,
  // Byte port
  ram_port_if.mem port
);

  // The port address is one byte wide, so every code must be backed.
  if (DEPTH != data_map_pkg::RAM_BYTES) begin : g_depth_check
    $error("internal RAM depth must match the byte address range");
  end

  logic [7:0]               mem [DEPTH]; // RL11
  data_map_pkg::ram_state_s st;
  data_map_pkg::ram_state_s next_st;

  always_comb begin
    next_st = st;
    if (port.en) begin
      next_st.rdata = mem[port.addr];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // The array has no reset; contents are undefined until written.
  always_ff @(posedge clk_sys) begin
    if (port.en && port.we) begin
      mem[port.addr] <= port.wdata;
    end
  end

  assign port.rdata = st.rdata;

endmodule

// [logic/status_word_and_data_memory_map.sv]
// Function
// (RL1) Carry set on add carry or subtract borrow, cleared by other arithmetic.
// (RL2) Half carry set on nibble carry or borrow, cleared otherwise.
// (RL3) Bits 5 and 1 are software flags that hardware never changes.
// (RL4) Bank field at bits 4:3 picks an eight-byte register bank.
// (RL5) Sign error set on signed overflow from add, add with carry, subtract.
// (RL6) Sign error set when a product exceeds 255.
// (RL7) Sign error set when a quotient has a zero divisor.
// (RL8) Those five operations clear sign error when no overflow occurs.
// (RL9) Bit 0 is read-only odd parity of the accumulator, tracked continuously.
// (RL10) Status byte lives at 0xD0, byte and bit accessible, resets zero.
// (RL11) Internal RAM holds 256 bytes at addresses 0x00 to 0xFF.
// (RL12) Lower 128 bytes reachable by direct and indirect modes.
// (RL13) Upper 128 bytes reachable only indirectly, separate from registers.
// (RL14) Direct access above 0x7F goes to the special register space.
// (RL15) Indirect access above 0x7F goes to upper RAM.
// (RL16) Indirect pointer comes from register 0 or 1 of current bank.
// (RL17) Bytes 0x20 to 0x2F hold 128 bits, at eight times offset plus bit.
// (RL18) Operand type alone chooses bit space or byte space.
// (RL19) Push writes at pointer plus one, then increments the pointer.
// (RL20) Reset loads the stack pointer with 0x07.
// (RL21) Code reads go to flash; external moves go to aux RAM or flash.
// (RL22) Software writes to the parity bit are ignored.
`timescale 1ns/10ps
module status_word_and_data_memory_map (
  // Clock and reset
  input  logic                    clk_sys,
  input  logic                    rst,
  // Data space request from the core
  input  logic                    reqValid,
  output logic                    reqReady,
  input  data_map_pkg::req_kind_e reqKind,
  input  logic                    reqWrite,
  input  logic [15:0]             reqAddr,
  input  logic [7:0]              reqData,
  output logic                    doneValid,
  output logic [7:0]              rdData,
  // Arithmetic flag update
  input  logic                    aluValid,
  input  data_map_pkg::alu_op_e   aluOp,
  input  logic [7:0]              aluA,
  input  logic [7:0]              aluB,
  // Accumulator and status view
  input  logic [7:0]              accValue,
  output logic [7:0]              programStatusByte,
  output logic [7:0]              stackTopPointer,
  output logic [1:0]              bankSelect,
  // Special register space outside this block
  output logic                    sfrRead,
  output logic                    sfrWrite,
  output logic [7:0]              sfrAddr,
  output logic [7:0]              sfrWdata,
  output logic [7:0]              sfrMask,
  input  logic [7:0]              sfrRdata,
  // Program flash and auxiliary RAM
  input  logic                    flashWriteMode,
  output logic                    codeRead,
  output logic                    auxRead,
  output logic                    auxWrite,
  output logic                    flashWrite,
  output logic [15:0]             extAddr,
  output logic [7:0]              extWdata
);

  localparam int CY = data_map_pkg::CARRY_POS;
  localparam int HC = data_map_pkg::HALF_POS;
  localparam int U0 = data_map_pkg::USER0_POS;
  localparam int U1 = data_map_pkg::USER1_POS;
  localparam int OV = data_map_pkg::SIGN_POS;
  localparam int PB = data_map_pkg::PARITY_POS;

  data_map_pkg::map_state_s st;
  data_map_pkg::map_state_s next_st;

  ram_port_if ram ();

  internal_data_ram #(
    .DEPTH (data_map_pkg::RAM_BYTES)
  ) u_ram (
    .clk_sys (clk_sys),
    .rst     (rst),
    .port    (ram.mem)
  );

  function automatic logic [7:0] bitMask(input logic [2:0] pos);
    return 8'h01 << pos;
  endfunction

  function automatic logic [7:0] mergeBit(input logic [7:0] b,
                                          input logic [2:0] pos,
                                          input logic       v);
    return v ? (b | bitMask(pos)) : (b & ~bitMask(pos));
  endfunction

  // Byte that holds a given bit address, in RAM or register space.
  function automatic logic [7:0] bitHome(input logic [7:0] a);
    return a[7] ? {a[7:3], 3'b000}
                : data_map_pkg::BIT_AREA + {4'h0, a[6:3]};
  endfunction

  logic       accept;
  logic [7:0] bankBase;
  logic [7:0] bitByte;
  logic [7:0] stackNext;
  logic       carryIn;
  logic [8:0] sum9;
  logic [4:0] sumLo;
  logic [8:0] dif9;
  logic [4:0] difLo;
  logic [15:0] product;
  logic [7:0] finalByte;

  assign reqReady  = (st.phase == data_map_pkg::ST_IDLE);
  assign accept    = reqValid && reqReady;
  assign bankBase  = {3'b000, st.status[data_map_pkg::BANK_HI:
                                        data_map_pkg::BANK_LO], 3'b000};
  assign bitByte   = bitHome(reqAddr[7:0]);
  assign stackNext = st.stackTop + 8'h01;
  assign carryIn   = (aluOp != data_map_pkg::ALU_ADD) && st.status[CY];
  assign sum9      = {1'b0, aluA} + {1'b0, aluB} + {8'h00, carryIn};
  assign sumLo     = {1'b0, aluA[3:0]} + {1'b0, aluB[3:0]}
                   + {4'h0, carryIn};
  assign dif9      = {1'b0, aluA} - {1'b0, aluB} - {8'h00, carryIn};
  assign difLo     = {1'b0, aluA[3:0]} - {1'b0, aluB[3:0]}
                   - {4'h0, carryIn};
  assign product   = {8'h00, aluA} * {8'h00, aluB};

  always_comb begin
    finalByte = st.hold;
    unique case (st.src)
      data_map_pkg::SRC_RAM:  finalByte = ram.rdata;
      data_map_pkg::SRC_SFR:  finalByte = sfrRdata;
      default:                finalByte = st.hold;
    endcase
  end

  always_comb begin
    next_st            = st;
    next_st.doneValid  = 1'b0;
    next_st.sfrRead    = 1'b0;
    next_st.sfrWrite   = 1'b0;
    next_st.codeRead   = 1'b0;
    next_st.auxRead    = 1'b0;
    next_st.auxWrite   = 1'b0;
    next_st.flashWrite = 1'b0;
    next_st.status[PB] = ^accValue; // RL9
    ram.en    = 1'b0;
    ram.we    = 1'b0;
    ram.addr  = 8'h00;
    ram.wdata = reqData;
    unique case (st.phase)
      data_map_pkg::ST_IDLE: begin
        if (accept) begin
          next_st.phase   = data_map_pkg::ST_FINISH;
          next_st.src     = data_map_pkg::SRC_HOLD;
          next_st.hold    = 8'h00;
          next_st.isBit   = 1'b0;
          next_st.isWrite = reqWrite;
          next_st.wrData  = reqData;
          next_st.bitPos  = reqAddr[2:0];
          next_st.addr    = bitByte;
          unique case (reqKind)
            data_map_pkg::REQ_DIRECT: begin
              if (reqAddr[7:0] <= data_map_pkg::DIRECT_TOP) begin
                ram.en      = 1'b1; // RL12
                ram.we      = reqWrite;
                ram.addr    = reqAddr[7:0];
                next_st.src = data_map_pkg::SRC_RAM;
              end else if (reqAddr[7:0] == data_map_pkg::STATUS_ADDR) begin
                next_st.hold = st.status; // RL10
                if (reqWrite) begin
                  next_st.status[CY:U1] = reqData[CY:U1]; // RL22
                end
              end else if (reqAddr[7:0] == data_map_pkg::STACK_ADDR) begin
                next_st.hold = st.stackTop;
                if (reqWrite) begin
                  next_st.stackTop = reqData;
                end
              end else begin
                // Everything else above the direct limit is a register.
                next_st.sfrRead  = !reqWrite; // RL14
                next_st.sfrWrite = reqWrite;
                next_st.sfrAddr  = reqAddr[7:0];
                next_st.sfrWdata = reqData;
                next_st.sfrMask  = data_map_pkg::FULL_MASK;
                next_st.src      = data_map_pkg::SRC_SFR;
              end
            end
            data_map_pkg::REQ_INDIRECT: begin
              // Fetch the pointer from register 0 or 1 of the bank.
              ram.en        = 1'b1;
              ram.addr      = bankBase | {7'h00, reqAddr[0]}; // RL16
              next_st.phase = data_map_pkg::ST_POINTER;
            end
            data_map_pkg::REQ_REG: begin
              ram.en      = 1'b1;
              ram.we      = reqWrite;
              ram.addr    = bankBase | {5'h00, reqAddr[2:0]}; // RL4
              next_st.src = data_map_pkg::SRC_RAM;
            end
            data_map_pkg::REQ_BIT: begin
              next_st.isBit = 1'b1; // RL18
              if (!reqAddr[7]) begin
                // RAM bits are read here and merged back when done.
                ram.en      = 1'b1; // RL17
                ram.addr    = bitByte;
                next_st.src = data_map_pkg::SRC_RAM;
              end else if (bitByte == data_map_pkg::STATUS_ADDR) begin
                next_st.hold = st.status; // RL10
                if (reqWrite && reqAddr[2:0] != 3'(PB)) begin
                  next_st.status = mergeBit(next_st.status,
                                            reqAddr[2:0], reqData[0]);
                end
              end else begin
                next_st.sfrRead  = !reqWrite;
                next_st.sfrWrite = reqWrite;
                next_st.sfrAddr  = bitByte;
                next_st.sfrWdata = {8{reqData[0]}};
                next_st.sfrMask  = bitMask(reqAddr[2:0]);
                next_st.src      = data_map_pkg::SRC_SFR;
              end
            end
            data_map_pkg::REQ_PUSH: begin
              ram.en           = 1'b1; // RL19
              ram.we           = 1'b1;
              ram.addr         = stackNext;
              next_st.stackTop = stackNext;
            end
            data_map_pkg::REQ_POP: begin
              ram.en           = 1'b1;
              ram.addr         = st.stackTop;
              next_st.stackTop = st.stackTop - 8'h01;
              next_st.src      = data_map_pkg::SRC_RAM;
            end
            data_map_pkg::REQ_CODE: begin
              next_st.codeRead = !reqWrite; // RL21
              next_st.extAddr  = reqAddr;
            end
            data_map_pkg::REQ_EXT: begin
              next_st.auxRead    = !reqWrite; // RL21
              next_st.auxWrite   = reqWrite && !flashWriteMode;
              next_st.flashWrite = reqWrite && flashWriteMode;
              next_st.extAddr    = reqAddr;
              next_st.extWdata   = reqData;
            end
          endcase
        end
      end
      data_map_pkg::ST_POINTER: begin
        // Any pointer value is legal; above the limit it is upper RAM.
        ram.en        = 1'b1; // RL15
        ram.we        = st.isWrite;
        ram.addr      = ram.rdata; // RL13
        ram.wdata     = st.wrData;
        next_st.src   = data_map_pkg::SRC_RAM;
        next_st.phase = data_map_pkg::ST_FINISH;
      end
      data_map_pkg::ST_FINISH: begin
        next_st.phase     = data_map_pkg::ST_IDLE;
        next_st.doneValid = 1'b1;
        next_st.rdData    = st.isBit ? {7'h00, finalByte[st.bitPos]}
                                     : finalByte;
        if (st.isBit && st.isWrite && st.src == data_map_pkg::SRC_RAM) begin
          ram.en    = 1'b1; // RL17
          ram.we    = 1'b1;
          ram.addr  = st.addr;
          ram.wdata = mergeBit(ram.rdata, st.bitPos, st.wrData[0]);
        end
      end
      default: next_st.phase = data_map_pkg::ST_IDLE;
    endcase
    // Flag updates come last so an arithmetic result beats a write.
    if (aluValid) begin
      unique case (aluOp)
        data_map_pkg::ALU_ADD, data_map_pkg::ALU_ADD_WITH_CARRY_OP: begin
          next_st.status[CY] = sum9[8]; // RL1
          next_st.status[HC] = sumLo[4]; // RL2
          next_st.status[OV] = (aluA[7] == aluB[7])
                            && (sum9[7] != aluA[7]); // RL5
        end
        data_map_pkg::ALU_SUBTRACT_BORROW_OP: begin
          next_st.status[CY] = dif9[8]; // RL1
          next_st.status[HC] = difLo[4]; // RL2
          next_st.status[OV] = (aluA[7] != aluB[7])
                            && (dif9[7] != aluA[7]); // RL5
        end
        data_map_pkg::ALU_MUL: begin
          next_st.status[CY] = 1'b0;
          next_st.status[HC] = 1'b0;
          next_st.status[OV] = |product[15:8]; // RL6
        end
        data_map_pkg::ALU_DIV: begin
          next_st.status[CY] = 1'b0;
          next_st.status[HC] = 1'b0;
          next_st.status[OV] = (aluB == 8'h00); // RL7 RL8
        end
        data_map_pkg::ALU_OTHER: begin
          next_st.status[CY] = 1'b0; // RL1
          next_st.status[HC] = 1'b0; // RL2
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st <= data_map_pkg::MAP_RESET; // RL20
    end else begin
      st <= next_st;
    end
  end

  assign doneValid         = st.doneValid;
  assign rdData            = st.rdData;
  assign programStatusByte = st.status; // RL3
  assign stackTopPointer   = st.stackTop;
  assign bankSelect        = st.status[data_map_pkg::BANK_HI:
                                       data_map_pkg::BANK_LO];
  assign sfrRead           = st.sfrRead;
  assign sfrWrite          = st.sfrWrite;
  assign sfrAddr           = st.sfrAddr;
  assign sfrWdata          = st.sfrWdata;
  assign sfrMask           = st.sfrMask;
  assign codeRead          = st.codeRead;
  assign auxRead           = st.auxRead;
  assign auxWrite          = st.auxWrite;
  assign flashWrite        = st.flashWrite;
  assign extAddr           = st.extAddr;
  assign extWdata          = st.extWdata;

  // Reference values computed apart from the datapath above.
  logic addOver;
  logic mulOver;
  logic divZero;
  logic accOdd;
  logic statusTouch;

  assign addOver = (int'(aluA) + int'(aluB)) > 255;
  assign mulOver = (int'(aluA) * int'(aluB)) > 255;
  assign divZero = (aluB == 8'h00);
  assign accOdd  = ^accValue;
  assign statusTouch = accept && reqWrite
    && ((reqKind == data_map_pkg::REQ_DIRECT
         && reqAddr[7:0] == data_map_pkg::STATUS_ADDR)
     || (reqKind == data_map_pkg::REQ_BIT && reqAddr[7]
         && bitByte == data_map_pkg::STATUS_ADDR));

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  carry_add_a: assert property ( // RL1
    aluValid && aluOp == data_map_pkg::ALU_ADD
    |=> programStatusByte[CY] == $past(addOver))
    else $error("carry flag wrong after add");
  half_clear_a: assert property ( // RL2
    aluValid && aluOp == data_map_pkg::ALU_OTHER |=> !programStatusByte[HC])
    else $error("half carry not cleared");
  user_keep_a: assert property ( // RL3
    !statusTouch |=> $stable(programStatusByte[U0])
                  && $stable(programStatusByte[U1]))
    else $error("user flag changed without a write");
  bank_reg_a: assert property ( // RL4
    accept && reqKind == data_map_pkg::REQ_REG
    |-> ram.en && ram.addr == {3'b000, bankSelect, reqAddr[2:0]})
    else $error("register access outside selected bank");
  sign_add_a: assert property ( // RL5
    aluValid && aluOp == data_map_pkg::ALU_ADD
    && aluA == 8'h7F && aluB == 8'h01 |=> programStatusByte[OV])
    else $error("signed overflow missed");
  sign_mul_a: assert property ( // RL6
    aluValid && aluOp == data_map_pkg::ALU_MUL
    |=> programStatusByte[OV] == $past(mulOver))
    else $error("product overflow flag wrong");
  sign_div_a: assert property ( // RL8
    aluValid && aluOp == data_map_pkg::ALU_DIV
    |=> programStatusByte[OV] == $past(divZero))
    else $error("divide flag wrong");
  parity_keep_a: assert property ( // RL22
    statusTouch |=> programStatusByte[PB] == $past(accOdd))
    else $error("parity bit took a software value");
  direct_sfr_a: assert property ( // RL14
    accept && reqKind == data_map_pkg::REQ_DIRECT
    && reqAddr[7:0] > data_map_pkg::DIRECT_TOP |-> !ram.en)
    else $error("direct high access reached RAM");
  ind_ptr_a: assert property ( // RL16
    accept && reqKind == data_map_pkg::REQ_INDIRECT
    |-> ram.addr == {3'b000, bankSelect, 2'b00, reqAddr[0]}
    ##1 ram.en && ram.addr == ram.rdata ##2 doneValid)
    else $error("indirect pointer path wrong");
  push_sp_a: assert property ( // RL19
    accept && reqKind == data_map_pkg::REQ_PUSH
    |-> ram.we && ram.addr == stackNext
    ##1 stackTopPointer == $past(stackNext))
    else $error("push order wrong");
  bit_ram_a: assert property ( // RL17
    accept && reqKind == data_map_pkg::REQ_BIT && !reqAddr[7]
    |-> ram.addr == data_map_pkg::BIT_AREA + {4'h0, reqAddr[6:3]})
    else $error("bit address maps to wrong byte");
  ext_flash_a: assert property ( // RL21
    accept && reqKind == data_map_pkg::REQ_EXT && reqWrite
    && flashWriteMode |=> flashWrite && !auxWrite)
    else $error("external write not steered to flash");

  push_c: cover property (accept && reqKind == data_map_pkg::REQ_PUSH);
  ind_wr_c: cover property (
    accept && reqKind == data_map_pkg::REQ_INDIRECT && reqWrite);
  bit_wr_c: cover property (
    accept && reqKind == data_map_pkg::REQ_BIT && reqWrite && !reqAddr[7]);
  mul_ov_c: cover property (
    aluValid && aluOp == data_map_pkg::ALU_MUL && mulOver);

endmodule

// [tb/sfr_space_model.sv]
`timescale 1ns/10ps
module sfr_space_model (
  // Clock
  input  logic       clk_sys,
  // Register space strobes
  input  logic       sfrRead,
  input  logic       sfrWrite,
  input  logic [7:0] sfrAddr,
  input  logic [7:0] sfrWdata,
  input  logic [7:0] sfrMask,
  output logic [7:0] sfrRdata
);
  logic [7:0] regs [256];

  always_ff @(posedge clk_sys) begin
    if (sfrWrite) begin
      regs[sfrAddr] <= (regs[sfrAddr] & ~sfrMask) | (sfrWdata & sfrMask);
    end
  end
  // Outside a read strobe the inverse shows, so stale data never passes.
  assign sfrRdata = sfrRead ? regs[sfrAddr] : ~regs[sfrAddr];
endmodule

// [tb/status_word_and_data_memory_map_bench.sv]
`timescale 1ns/10ps
`define CHK(g, e) chk(((g) !== (e)), 16'(g), 16'(e))
module status_word_and_data_memory_map_bench;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic reqValid = 1'b0;
  logic reqReady, doneValid, reqWrite, aluValid = 1'b0;
  data_map_pkg::req_kind_e reqKind = data_map_pkg::REQ_DIRECT;
  data_map_pkg::alu_op_e aluOp = data_map_pkg::ALU_ADD;
  logic [15:0] reqAddr = 16'h0000;
  logic [15:0] extAddr;
  logic [7:0] reqData, rdData, aluA, aluB, accValue, programStatusByte;
  logic [7:0] stackTopPointer, sfrAddr, sfrWdata, sfrMask, sfrRdata;
  logic [7:0] extWdata, rd, st, a, d, x;
  logic [6:0] ba;
  logic [1:0] bankSelect;
  logic sfrRead, sfrWrite, flashWriteMode = 1'b0, v;
  logic codeRead, auxRead, auxWrite, flashWrite;
  logic [15:0] rnd = 16'h770A;
  int nFail = 0, checkCount = 0, nCode = 0, nAux = 0, nFlash = 0, nRd = 0;

  status_word_and_data_memory_map dut_u (.*);
  sfr_space_model sfr_u (.clk_sys(clk_sys), .sfrRead(sfrRead),
    .sfrWrite(sfrWrite), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata),
    .sfrMask(sfrMask), .sfrRdata(sfrRdata));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    nCode <= nCode + int'(codeRead);
    nAux <= nAux + int'(auxWrite);
    nFlash <= nFlash + int'(flashWrite);
    nRd <= nRd + int'(auxRead);
  end

  function automatic logic [7:0] rand8();
    rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
    return rnd[7:0];
  endfunction
  // Returns carry, half carry and sign error after one operation.
  function automatic logic [2:0] flags(data_map_pkg::alu_op_e o,
      logic [7:0] p, q, logic c, ov);
    logic [8:0] s;
    logic [4:0] h;
    logic [15:0] m;
    m = p * q;
    if (o == data_map_pkg::ALU_SUBTRACT_BORROW_OP) begin
      s = {1'b0, p} - {1'b0, q} - 9'(c);
      h = {1'b0, p[3:0]} - {1'b0, q[3:0]} - 5'(c);
      return {s[8], h[4], (p[7] != q[7]) && (s[7] != p[7])};
    end
    c = c && (o == data_map_pkg::ALU_ADD_WITH_CARRY_OP);
    s = {1'b0, p} + {1'b0, q} + 9'(c);
    h = {1'b0, p[3:0]} + {1'b0, q[3:0]} + 5'(c);
    case (o)
      data_map_pkg::ALU_ADD,
      data_map_pkg::ALU_ADD_WITH_CARRY_OP:
        return {s[8], h[4], (p[7] == q[7]) && (s[7] != p[7])};
      data_map_pkg::ALU_MUL: return {2'b00, |m[15:8]};
      data_map_pkg::ALU_DIV: return {2'b00, q == 8'h00};
      default: return {2'b00, ov};
    endcase
  endfunction

  task automatic wrapUp();
    $display("checks %0d mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic bad, input logic [15:0] g, e);
    checkCount++;
    if (bad) begin
      nFail++;
      $display("BAD at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic req(data_map_pkg::req_kind_e k, logic w, logic [15:0] ad,
      logic [7:0] dt);
    int i;
    reqKind = k;
    reqWrite = w;
    reqAddr = ad;
    reqData = dt;
    reqValid = 1'b1;
    @(negedge clk_sys);
    reqValid = 1'b0;
    for (i = 0; i < 8 && doneValid !== 1'b1; i++) @(negedge clk_sys);
    if (i == 8) begin
      nFail++;
      wrapUp();
    end else begin
      rd = rdData;
    end
  endtask
  task automatic alu(data_map_pkg::alu_op_e o, logic [7:0] p, q);
    {st[7:6], st[2]} = flags(o, p, q, st[7], st[2]);
    aluOp = o;
    aluA = p;
    aluB = q;
    aluValid = 1'b1;
    @(negedge clk_sys);
    `CHK(programStatusByte[7:1], st[7:1]);
  endtask

  initial begin
    {reqWrite, reqData, aluA, aluB, accValue} = '0;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    `CHK(programStatusByte, 8'h00);
    `CHK(stackTopPointer, 8'h07);
    d = rand8();
    req(data_map_pkg::REQ_PUSH, 1'b1, 16'h0000, d);
    `CHK(stackTopPointer, 8'h08);
    req(data_map_pkg::REQ_DIRECT, 1'b0, 16'h0008, 8'h00);
    `CHK(rd, d);
    req(data_map_pkg::REQ_POP, 1'b0, 16'h0000, 8'h00);
    `CHK(rd, d);
    `CHK(stackTopPointer, 8'h07);
    $display("stack done");
    a = 8'h30 + (rand8() & 8'h3F);
    req(data_map_pkg::REQ_DIRECT, 1'b1, {8'h00, a}, d);
    req(data_map_pkg::REQ_REG, 1'b1, 16'h0000, a);
    req(data_map_pkg::REQ_INDIRECT, 1'b0, 16'h0000, 8'h00);
    `CHK(rd, d);
    for (int j = 0; j < 2; j++) begin
      a = j ? 8'hFF : 8'h90;
      x = rand8();
      req(data_map_pkg::REQ_REG, 1'b1, 16'h0001, a);
      req(data_map_pkg::REQ_DIRECT, 1'b1, {8'h00, a}, x);
      req(data_map_pkg::REQ_INDIRECT, 1'b1, 16'h0001, ~x);
      req(data_map_pkg::REQ_DIRECT, 1'b0, {8'h00, a}, 8'h00);
      `CHK(rd, x);
      req(data_map_pkg::REQ_INDIRECT, 1'b0, 16'h0001, 8'h00);
      `CHK(rd, ~x);
    end
    // Bit 3 of the register at 0x90, reached through the bit space.
    req(data_map_pkg::REQ_BIT, 1'b1, 16'h0093, 8'h01);
    req(data_map_pkg::REQ_BIT, 1'b0, 16'h0093, 8'h00);
    `CHK(rd, 8'h01);
    $display("ram done");
    for (int b = 0; b < 4; b++) begin
      st = {3'b000, 2'(b), 3'b000};
      req(data_map_pkg::REQ_DIRECT, 1'b1, 16'h00D0, st);
      `CHK(bankSelect, 2'(b));
      a = rand8() & 8'h07;
      d = rand8();
      req(data_map_pkg::REQ_REG, 1'b1, {8'h00, a}, d);
      req(data_map_pkg::REQ_DIRECT, 1'b0, {11'h000, 2'(b), a[2:0]}, 8'h00);
      `CHK(rd, d);
      req(data_map_pkg::REQ_DIRECT, 1'b0, 16'h00D0, 8'h00);
      `CHK(rd[7:1], st[7:1]);
    end
    $display("bank done");
    for (int j = 0; j < 4; j++) begin
      ba = j ? 7'(rand8()) : 7'h7F;
      x = rand8();
      a = 8'h20 + {4'h0, ba[6:3]};
      req(data_map_pkg::REQ_DIRECT, 1'b1, {8'h00, a}, x);
      v = ~x[ba[2:0]];
      x[ba[2:0]] = v;
      req(data_map_pkg::REQ_BIT, 1'b1, {9'h000, ba}, {7'h00, v});
      req(data_map_pkg::REQ_DIRECT, 1'b0, {8'h00, a}, 8'h00);
      `CHK(rd, x);
      req(data_map_pkg::REQ_BIT, 1'b0, {9'h000, ba}, 8'h00);
      `CHK(rd, {7'h00, v});
    end
    $display("bit done");
    req(data_map_pkg::REQ_DIRECT, 1'b1, 16'h00D0, 8'hFF);
    accValue = rand8();
    repeat (2) @(negedge clk_sys);
    `CHK(programStatusByte, {7'h7F, ^accValue});
    req(data_map_pkg::REQ_BIT, 1'b1, 16'h00D5, 8'h00);
    req(data_map_pkg::REQ_BIT, 1'b1, 16'h00D0, {7'h00, ~^accValue});
    `CHK(programStatusByte, {7'h6F, ^accValue});
    st = 8'h22;
    req(data_map_pkg::REQ_DIRECT, 1'b1, 16'h00D0, st);
    alu(data_map_pkg::ALU_DIV, 8'h05, 8'h00);
    alu(data_map_pkg::ALU_MUL, 8'h10, 8'h10);
    alu(data_map_pkg::ALU_ADD, 8'h7F, 8'h01);
    alu(data_map_pkg::ALU_SUBTRACT_BORROW_OP, 8'h00, 8'h01);
    for (int j = 0; j < 40; j++) begin
      alu(data_map_pkg::alu_op_e'(rand8() % 6), rand8(), rand8());
    end
    aluValid = 1'b0;
    $display("alu done");
    a = rand8();
    x = rand8();
    req(data_map_pkg::REQ_EXT, 1'b1, {a, rand8()}, x);
    `CHK(nAux, 1);
    `CHK(extWdata, x);
    `CHK(extAddr[15:8], a);
    flashWriteMode = 1'b1;
    req(data_map_pkg::REQ_EXT, 1'b1, {a, 8'h00}, rand8());
    `CHK(nFlash, 1);
    req(data_map_pkg::REQ_CODE, 1'b0, {a, 8'h01}, 8'h00);
    `CHK(nCode, 1);
    req(data_map_pkg::REQ_EXT, 1'b0, {a, 8'h02}, 8'h00);
    `CHK(nRd, 1);
    `CHK(nFlash, 1);
    $display("move done");
    wrapUp();
  end
endmodule
